// ===== design/cipher_map.svh
// Address map, field positions, reset values and timing counts of the cipher block.
// Assumes byte addresses on a 12-bit register port and 32-bit write and read data.
`ifndef CIPHER_MAP_SVH
`define CIPHER_MAP_SVH

// ==========================================================
// Register offsets
`define CTRL_ADDR 12'h540
`define IRQ_STS_ADDR 12'h544
`define IRQ_MASK_ADDR 12'h545
`define DMA_CFG_ADDR 12'h546
`define WIN_FIRST 12'h548
`define WIN_LAST 12'h54B
`define KEY_FIRST 12'h550
`define KEY_LAST 12'h55F

// ==========================================================
// Fields and reset values
`define CTRL_DEC_BIT 0
`define CTRL_NEED_BIT 1
`define CTRL_RDY_BIT 2
`define CTRL_CCM_BIT 7
`define CTRL_RESET 8'h02
`define DMA_EN_BIT 0
`define IRQ_DONE_BIT 0
`define IRQ_TAKEN_BIT 1
`define IRQ_WIDTH 2

// ==========================================================
// Timing and sequence counts
`define OP_CYCLES 1000
`define ROUNDS 4'hA
`define LAST_WORD 2'h3

// ==========================================================
// Cipher constants
`define RCON_FIRST 8'h01
`define RCON_LAST 8'h36
`define GF_POLY 8'h1B
`define SBOX_AFFINE 8'h63
`define INV_AFFINE 8'h05
`define MIX_ENC 32'h02030101
`define MIX_DEC 32'h0E0B0D09

`endif

// ===== design/cipher_pkg.sv
// Types shared by the cipher block.
// Assumes nothing beyond a SystemVerilog compiler.
package cipher_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_PREP = 3'b001,
    ST_EXPAND = 3'b010,
    ST_ROUND = 3'b011,
    ST_WAIT = 3'b100,
    ST_DRAIN = 3'b101
  } seq_state_e;

endpackage

// ===== design/cipher_round.sv
// One cipher round and one key-schedule step, purely combinational.
// Assumes the caller registers state, round key and round constant each cycle.
`timescale 1ns/10ps
`include "cipher_map.svh"
module cipher_round
  import cipher_pkg::*;
(
  input wire logic [127:0] i_state,
  input wire logic [127:0] i_key,
  input wire logic [7:0] i_rcon,
  input wire logic i_dec,
  input wire logic i_last,
  output logic [127:0] o_state,
  output logic [127:0] o_key,
  output logic [7:0] o_rcon
);

  // ==========================================================
  // Field arithmetic
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? `GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // Inverse as a^254; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] y;
    logic [7:0] r;
    y = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++)
    begin
      y = gmul(y, y);
      r = gmul(r, y);
    end
    return r;
  endfunction

  function automatic logic [7:0] rl(input logic [7:0] b, input int n);
    logic [15:0] t;
    t = {b, b} << n;
    return t[15:8];
  endfunction

  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ `SBOX_AFFINE;
  endfunction

  function automatic logic [7:0] isb(input logic [7:0] a);
    return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ `INV_AFFINE);
  endfunction

  function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
    return {sb(w[23:16]) ^ rc, sb(w[15:8]), sb(w[7:0]), sb(w[31:24])};
  endfunction

  // ==========================================================
  // Round datapath
  logic [7:0] a [16];
  logic [7:0] b [16];
  logic [7:0] k [16];
  logic [31:0] coef;
  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;

  always_comb
  begin
    w0 = i_key[127:96];
    w1 = i_key[95:64];
    w2 = i_key[63:32];
    w3 = i_key[31:0];
    if (i_dec)
    begin
      // Step the schedule backwards
      o_key[31:0] = w3 ^ w2;
      o_key[63:32] = w2 ^ w1;
      o_key[95:64] = w1 ^ w0;
      o_key[127:96] = w0 ^ subrot(w3 ^ w2, i_rcon);
      o_rcon = i_rcon[0] ? {1'b1, i_rcon[7:1] ^ 7'(`GF_POLY >> 1)} : {1'b0, i_rcon[7:1]};
      coef = `MIX_DEC;
    end
    else
    begin
      o_key[127:96] = w0 ^ subrot(w3, i_rcon);
      o_key[95:64] = w1 ^ o_key[127:96];
      o_key[63:32] = w2 ^ o_key[95:64];
      o_key[31:0] = w3 ^ o_key[63:32];
      o_rcon = xt(i_rcon);
      coef = `MIX_ENC;
    end
    for (int i = 0; i < 16; i++)
    begin
      a[i] = i_state[127 - 8 * i -: 8];
      k[i] = o_key[127 - 8 * i -: 8];
    end
    for (int c = 0; c < 4; c++)
    begin
      for (int r = 0; r < 4; r++)
      begin
        if (i_dec) b[4 * c + r] = isb(a[4 * ((c - r + 4) % 4) + r]) ^ k[4 * c + r];
        else b[4 * c + r] = sb(a[4 * ((c + r) % 4) + r]);
      end
    end
    for (int c = 0; c < 4; c++)
    begin
      for (int r = 0; r < 4; r++)
      begin
        a[4 * c + r] = 8'h00;
        for (int j = 0; j < 4; j++)
          a[4 * c + r] = a[4 * c + r] ^ gmul(b[4 * c + (r + j) % 4], coef[31 - 8 * j -: 8]);
        if (i_last) a[4 * c + r] = b[4 * c + r];
        if (!i_dec) a[4 * c + r] = a[4 * c + r] ^ k[4 * c + r];
      end
    end
    for (int i = 0; i < 16; i++)
      o_state[127 - 8 * i -: 8] = a[i];
  end

endmodule // cipher_round

// ===== design/block_cipher_accelerator.sv
// 128-bit block cipher accelerator with register port, stream port and interrupt.
// Assumes a same-clock register master and a same-clock stream source and sink.
//
// Functional notes
// - Encrypts or decrypts one 128-bit block with the 128-bit key.
// - One block completes in a fixed 1000 clock cycles, no software steps.
// - Block data arrives from register writes or from the stream port.
// - Control bit 0 selects decrypt when one, encrypt when zero.
// - Four window writes supply the block; four window reads return the result.
// - Input-needed flag clears once the fourth word is written.
// - Output-ready sets when finished and clears after the fourth window read.
// - Chaining is off after reset; output depends only on current inputs.
// - Control bit 7 enables chaining; previous result is mixed into the output.
// - Ready reads zero until a result exists; control resets to 0x02.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "cipher_map.svh"
module block_cipher_accelerator
  import cipher_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  input wire logic i_dma_in_valid,
  input wire logic [31:0] i_dma_in_data,
  output logic o_dma_in_ready,
  output logic o_dma_out_valid,
  output logic [31:0] o_dma_out_data,
  input wire logic i_dma_out_ready
);

  localparam logic [7:0] CtrlReset = `CTRL_RESET;
  localparam logic [9:0] OpLast = 10'(`OP_CYCLES - 1);
  localparam logic [3:0] RoundLast = 4'(`ROUNDS - 4'h1);

  // ==========================================================
  // State
  seq_state_e state_q;
  seq_state_e state_d;
  logic [7:0] key_q [16];
  logic [7:0] key_d [16];
  logic [127:0] key_flat;
  logic dec_q;
  logic dec_d;
  logic ccm_q;
  logic ccm_d;
  logic need_q;
  logic need_d;
  logic rdy_q;
  logic rdy_d;
  logic dma_en_q;
  logic dma_en_d;
  logic [`IRQ_WIDTH-1:0] sts_q;
  logic [`IRQ_WIDTH-1:0] sts_d;
  logic [`IRQ_WIDTH-1:0] mask_q;
  logic [`IRQ_WIDTH-1:0] mask_d;
  logic [`IRQ_WIDTH-1:0] evt;
  logic [127:0] st_q;
  logic [127:0] st_d;
  logic [127:0] rk_q;
  logic [127:0] rk_d;
  logic [7:0] rcon_q;
  logic [7:0] rcon_d;
  logic [3:0] rnd_q;
  logic [3:0] rnd_d;
  logic [9:0] cyc_q;
  logic [9:0] cyc_d;
  logic [1:0] wcnt_q;
  logic [1:0] wcnt_d;
  logic [1:0] ocnt_q;
  logic [1:0] ocnt_d;
  logic [127:0] res_q;
  logic [127:0] res_d;
  logic [127:0] prev_q;
  logic [127:0] prev_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic in_ready_q;
  logic in_ready_d;
  logic out_valid_q;
  logic out_valid_d;
  logic [31:0] out_data_q;
  logic [31:0] out_data_d;

  // ==========================================================
  // Round datapath
  logic [127:0] nx_state;
  logic [127:0] nx_key;
  logic [7:0] nx_rcon;
  logic round_dec;
  logic round_last;

  assign round_dec = (state_q == ST_ROUND) && dec_q;
  assign round_last = (rnd_q == RoundLast);

  cipher_round u_round (
    .i_state(st_q),
    .i_key(rk_q),
    .i_rcon(rcon_q),
    .i_dec(round_dec),
    .i_last(round_last),
    .o_state(nx_state),
    .o_key(nx_key),
    .o_rcon(nx_rcon)
  );

  // ==========================================================
  // Decode
  logic win_wr;
  logic win_rd;
  logic key_wr;
  logic in_take;
  logic out_take;
  logic [31:0] in_word;

  always_comb
  begin
    for (int i = 0; i < 16; i++)
      key_flat[127 - 8 * i -: 8] = key_q[i];
  end

  assign win_wr = i_wr && (i_addr >= `WIN_FIRST) && (i_addr <= `WIN_LAST);
  assign win_rd = i_rd && (i_addr >= `WIN_FIRST) && (i_addr <= `WIN_LAST);
  assign key_wr = i_wr && (i_addr >= `KEY_FIRST) && (i_addr <= `KEY_LAST);
  // Stream mode leaves the window to the stream port
  assign in_take = need_q && (dma_en_q ? (i_dma_in_valid && in_ready_q) : win_wr);
  assign in_word = dma_en_q ? i_dma_in_data : i_wdata;
  assign out_take = rdy_q && (dma_en_q ? (out_valid_q && i_dma_out_ready) : win_rd);

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_d = state_q;
    key_d = key_q;
    dec_d = dec_q;
    ccm_d = ccm_q;
    need_d = need_q;
    rdy_d = rdy_q;
    dma_en_d = dma_en_q;
    mask_d = mask_q;
    evt = '0;
    st_d = st_q;
    rk_d = rk_q;
    rcon_d = rcon_q;
    rnd_d = rnd_q;
    cyc_d = cyc_q;
    wcnt_d = wcnt_q;
    ocnt_d = ocnt_q;
    res_d = res_q;
    prev_d = prev_q;

    // Software writes
    if (key_wr) key_d[i_addr[3:0]] = i_wdata[7:0];
    if (i_wr && (i_addr == `CTRL_ADDR))
    begin
      dec_d = i_wdata[`CTRL_DEC_BIT];
      ccm_d = i_wdata[`CTRL_CCM_BIT];
    end
    if (i_wr && (i_addr == `DMA_CFG_ADDR)) dma_en_d = i_wdata[`DMA_EN_BIT];
    if (i_wr && (i_addr == `IRQ_MASK_ADDR)) mask_d = i_wdata[`IRQ_WIDTH-1:0];

    // Sequencer
    if ((state_q != ST_LOAD) && (state_q != ST_DRAIN)) cyc_d = cyc_q + 10'h001;
    case (state_q)
      ST_LOAD:
      begin
        if (in_take)
        begin
          st_d[{~wcnt_q, 5'h00} +: 32] = in_word;
          wcnt_d = wcnt_q + 2'h1;
          if (wcnt_q == `LAST_WORD)
          begin
            need_d = 1'b0;
            cyc_d = '0;
            evt[`IRQ_TAKEN_BIT] = 1'b1;
            state_d = ST_PREP;
          end
        end
      end
      ST_PREP:
      begin
        rk_d = key_flat;
        rcon_d = `RCON_FIRST;
        rnd_d = '0;
        if (dec_q)
          state_d = ST_EXPAND;
        else
        begin
          st_d = st_q ^ key_flat;
          state_d = ST_ROUND;
        end
      end
      ST_EXPAND:
      begin
        // Walk the schedule to the last round key
        rk_d = nx_key;
        rcon_d = nx_rcon;
        rnd_d = rnd_q + 4'h1;
        if (round_last)
        begin
          st_d = st_q ^ nx_key;
          rcon_d = `RCON_LAST;
          rnd_d = '0;
          state_d = ST_ROUND;
        end
      end
      ST_ROUND:
      begin
        st_d = nx_state;
        rk_d = nx_key;
        rcon_d = nx_rcon;
        rnd_d = rnd_q + 4'h1;
        if (round_last) state_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cyc_q == OpLast)
        begin
          res_d = st_q ^ (ccm_q ? prev_q : '0);
          prev_d = res_d;
          rdy_d = 1'b1;
          ocnt_d = '0;
          evt[`IRQ_DONE_BIT] = 1'b1;
          state_d = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        if (out_take)
        begin
          ocnt_d = ocnt_q + 2'h1;
          if (ocnt_q == `LAST_WORD)
          begin
            rdy_d = 1'b0;
            need_d = 1'b1;
            wcnt_d = '0;
            state_d = ST_LOAD;
          end
        end
      end
      default:
      begin
        state_d = ST_LOAD;
      end
    endcase

    // Sticky status, write one to clear, set wins
    sts_d = sts_q;
    if (i_wr && (i_addr == `IRQ_STS_ADDR)) sts_d = sts_q & ~i_wdata[`IRQ_WIDTH-1:0];
    sts_d = sts_d | evt;
    irq_d = |(sts_d & mask_d);

    // Stream port
    in_ready_d = need_d && dma_en_d;
    out_valid_d = rdy_d && dma_en_d;
    out_data_d = res_d[{~ocnt_d, 5'h00} +: 32];

    // Read data, one cycle after the strobe
    rdata_d = '0;
    if (i_rd)
    begin
      if (i_addr == `CTRL_ADDR)
      begin
        rdata_d[`CTRL_DEC_BIT] = dec_q;
        rdata_d[`CTRL_NEED_BIT] = need_q;
        rdata_d[`CTRL_RDY_BIT] = rdy_q;
        rdata_d[`CTRL_CCM_BIT] = ccm_q;
      end
      else if (i_addr == `IRQ_STS_ADDR)
        rdata_d[`IRQ_WIDTH-1:0] = sts_q;
      else if (i_addr == `IRQ_MASK_ADDR)
        rdata_d[`IRQ_WIDTH-1:0] = mask_q;
      else if (i_addr == `DMA_CFG_ADDR)
        rdata_d[`DMA_EN_BIT] = dma_en_q;
      else if (win_rd && rdy_q && !dma_en_q)
        rdata_d = res_q[{~ocnt_q, 5'h00} +: 32];
      else if ((i_addr >= `KEY_FIRST) && (i_addr <= `KEY_LAST))
        rdata_d[7:0] = key_q[i_addr[3:0]];
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      state_q <= ST_LOAD;
      for (int i = 0; i < 16; i++)
        key_q[i] <= 8'h00;
      dec_q <= CtrlReset[`CTRL_DEC_BIT];
      ccm_q <= CtrlReset[`CTRL_CCM_BIT];
      need_q <= CtrlReset[`CTRL_NEED_BIT];
      rdy_q <= CtrlReset[`CTRL_RDY_BIT];
      dma_en_q <= 1'b0;
      sts_q <= '0;
      mask_q <= '0;
      st_q <= '0;
      rk_q <= '0;
      rcon_q <= `RCON_FIRST;
      rnd_q <= '0;
      cyc_q <= '0;
      wcnt_q <= '0;
      ocnt_q <= '0;
      res_q <= '0;
      prev_q <= '0;
      rdata_q <= '0;
      irq_q <= 1'b0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      key_q <= key_d;
      dec_q <= dec_d;
      ccm_q <= ccm_d;
      need_q <= need_d;
      rdy_q <= rdy_d;
      dma_en_q <= dma_en_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      st_q <= st_d;
      rk_q <= rk_d;
      rcon_q <= rcon_d;
      rnd_q <= rnd_d;
      cyc_q <= cyc_d;
      wcnt_q <= wcnt_d;
      ocnt_q <= ocnt_d;
      res_q <= res_d;
      prev_q <= prev_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_dma_in_ready = in_ready_q;
  assign o_dma_out_valid = out_valid_q;
  assign o_dma_out_data = out_data_q;

endmodule // block_cipher_accelerator

// ===== sim/block_cipher_accelerator_properties.sv
// Checker for the register, stream and interrupt ports of the cipher block.
// Assumes i_ce high while stream words move; bound to every instance of the block.
`timescale 1ns/10ps
`include "cipher_map.svh"
module cipher_checker
  import cipher_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire logic i_dma_in_valid,
  input wire logic [31:0] i_dma_in_data,
  input wire logic o_dma_in_ready,
  input wire logic o_dma_out_valid,
  input wire logic [31:0] o_dma_out_data,
  input wire logic i_dma_out_ready
);
  logic in_take;
  logic out_take;
  logic [1:0] in_cnt_q, in_cnt_d, out_cnt_q, out_cnt_d;
  logic [10:0] op_cnt_q, op_cnt_d;
  assign in_take = i_dma_in_valid && o_dma_in_ready && i_ce;
  assign out_take = o_dma_out_valid && i_dma_out_ready && i_ce;
  // ==========================================================
  // Stream word counters and cycles since the last block started
  always_comb
  begin
    in_cnt_d = in_cnt_q + {1'b0, in_take};
    out_cnt_d = out_cnt_q + {1'b0, out_take};
    op_cnt_d = op_cnt_q + {10'h000, op_cnt_q != 11'h7FF};
    if (in_take && in_cnt_q == 2'h3)
      op_cnt_d = 11'h001;
    if (!i_rst_b)
    begin
      in_cnt_d = 2'h0;
      out_cnt_d = 2'h0;
      op_cnt_d = 11'h7FF;
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    in_cnt_q <= in_cnt_d;
    out_cnt_q <= out_cnt_d;
    op_cnt_q <= op_cnt_d;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_reads_zero: assert property (i_rd && i_addr[11:8] != 4'h5 |=> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_input_ready_drop: assert property (in_take && in_cnt_q == 2'h3 |=> !o_dma_in_ready)
    else $error("input ready after fourth word");
  a_op_cycle_count: assert property ($rose(o_dma_out_valid) |->
    op_cnt_q >= 11'h3E8 && op_cnt_q <= 11'h3EA)
    else $error("result not after the fixed operation time");
  a_output_word_held: assert property (o_dma_out_valid && !i_dma_out_ready |=>
    o_dma_out_valid && $stable(o_dma_out_data))
    else $error("output word dropped before taken");
  a_output_last_word: assert property (out_take && out_cnt_q == 2'h3 |=>
    !o_dma_out_valid && o_dma_in_ready)
    else $error("output not closed after fourth word");
  a_mask_silences_irq: assert property (i_wr && i_addr == `IRQ_MASK_ADDR && i_wdata[1:0] == 2'h0
    |-> ##2 !o_irq)
    else $error("interrupt high with mask clear");
  a_reset_outputs_quiet: assert property (disable iff (1'b0) !i_rst_b && i_ce |=>
    o_rdata == 32'h0 && !o_irq && !o_dma_in_ready && !o_dma_out_valid)
    else $error("outputs not quiet after reset");
  c_stream_in: cover property (in_take && in_cnt_q == 2'h3);
  c_stream_out: cover property (out_take && out_cnt_q == 2'h3);
  c_irq: cover property ($rose(o_irq));
endmodule // cipher_checker

bind block_cipher_accelerator cipher_checker cipher_checker_i (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_dma_in_valid(i_dma_in_valid),
  .i_dma_in_data(i_dma_in_data), .o_dma_in_ready(o_dma_in_ready),
  .o_dma_out_valid(o_dma_out_valid), .o_dma_out_data(o_dma_out_data),
  .i_dma_out_ready(i_dma_out_ready));

// ===== sim/stream_partner.sv
// Behavioural stream source and sink on the far side of the stream port.
// Assumes the block's clock; words travel most significant first.
`timescale 1ns/10ps
module stream_partner
(
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [127:0] i_block,
  input wire logic i_in_ready,
  input wire logic i_out_valid,
  input wire logic [31:0] i_out_data,
  output logic o_in_valid = 1'b0,
  output logic [31:0] o_in_data = 32'h0,
  output logic o_out_ready = 1'b0,
  output logic [127:0] o_result = 128'h0,
  output logic [2:0] o_taken = 3'h0
);
  logic [2:0] sent = 3'h0;
  // ==========================================================
  // Source holds a word until taken, scrambles the released bus
  always @(posedge i_core_clk)
  begin
    if (i_go)
    begin
      sent <= 3'h0;
      o_in_valid <= 1'b1;
      o_in_data <= i_block[127:96];
    end
    else if (o_in_valid && i_in_ready)
    begin
      sent <= sent + 3'h1;
      o_in_valid <= sent < 3'h3;
      o_in_data <= sent < 3'h3 ? i_block[95 - 32 * sent -: 32] : ~o_in_data;
    end
  end
  // ==========================================================
  // Sink stalls every other cycle
  always @(posedge i_core_clk)
  begin
    o_out_ready <= ~o_out_ready;
    if (i_go)
      o_taken <= 3'h0;
    else if (i_out_valid && o_out_ready)
    begin
      o_result <= {o_result[95:0], i_out_data};
      o_taken <= o_taken + 3'h1;
    end
  end
endmodule // stream_partner

// ===== sim/test_block_cipher_accelerator.sv
// Self-checking bench: register mode, chaining, stream mode, interrupt, second reset.
// Assumes the stream partner model and the bound checker.
`timescale 1ns/10ps
`include "cipher_map.svh"
module test_block_cipher_accelerator
  import cipher_pkg::*;
;
  localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  typedef struct packed {logic dec; logic ccm; logic [127:0] din; logic [127:0] dout;} row_s;
  row_s rows [4];
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic go = 1'b0;
  logic [31:0] o_rdata, o_dma_out_data, i_dma_in_data, v;
  logic o_irq, i_dma_in_valid, o_dma_in_ready, o_dma_out_valid, i_dma_out_ready;
  logic [127:0] result, blk;
  logic [2:0] taken;
  int errors = 0, samples_checked = 0, cycles = 0, n;

  block_cipher_accelerator block_cipher_accelerator_i (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_dma_in_valid(i_dma_in_valid),
    .i_dma_in_data(i_dma_in_data), .o_dma_in_ready(o_dma_in_ready),
    .o_dma_out_valid(o_dma_out_valid), .o_dma_out_data(o_dma_out_data),
    .i_dma_out_ready(i_dma_out_ready));
  stream_partner stream_partner_i (.i_core_clk(i_core_clk), .i_go(go), .i_block(CT),
    .i_in_ready(o_dma_in_ready), .i_out_valid(o_dma_out_valid), .i_out_data(o_dma_out_data),
    .o_in_valid(i_dma_in_valid), .o_in_data(i_dma_in_data), .o_out_ready(i_dma_out_ready),
    .o_result(result), .o_taken(taken));

  always #2 i_core_clk = ~i_core_clk;

  // ==========================================================
  // Register port and comparison tasks
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] exp,
    input logic [31:0] m = 32'hFFFFFFFF);
    rd(a);
    chk(name, v & m, exp);
  endtask
  task automatic load_key();
    for (int k = 0; k < 16; k++)
      wr(12'(`KEY_FIRST + k), {24'h0, KEY[127 - 8 * k -: 8]});
  endtask
  task automatic run_row(input row_s r);
    wr(`CTRL_ADDR, {24'h0, r.ccm, 6'h00, r.dec});
    for (int w = 0; w < 4; w++)
      wr(12'(`WIN_FIRST + w), r.din[127 - 32 * w -: 32]);
    rc("need", `CTRL_ADDR, 32'h0, 32'h2);
    repeat (`OP_CYCLES - 20) @(posedge i_core_clk);
    rc("early", `CTRL_ADDR, 32'h0, 32'h4);
    n = 0;
    do
    begin
      rd(`CTRL_ADDR);
      n++;
    end
    while (!v[2] && n < 50);
    chk("polls", n, 9);
    for (int w = 0; w < 4; w++)
    begin
      rd(12'(`WIN_FIRST + w));
      blk = {blk[95:0], v};
    end
    chk("block", blk, r.dout);
    rc("extra", `WIN_FIRST, 32'h0);
    rc("flags", `CTRL_ADDR, {24'h0, r.ccm, 4'h0, 2'b01, r.dec}, 32'h87);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rows[0] = {1'b0, 1'b0, PT, CT};
    rows[1] = {1'b1, 1'b0, CT, PT};
    rows[2] = {1'b0, 1'b1, PT, CT ^ PT};
    rows[3] = {1'b1, 1'b0, CT, PT};
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rc("ctrl", `CTRL_ADDR, {24'h0, `CTRL_RESET});
    rc("key", 12'h553, 32'h0);
    rc("window", `WIN_FIRST, 32'h0);
    rc("unmapped", 12'h5F0, 32'h0);
    rc("unmapped low", 12'h140, 32'h0);
    $display("reset values done");
    load_key();
    foreach (rows[r])
    begin
      run_row(rows[r]);
      $display("row %0d done", r);
    end
    wr(`DMA_CFG_ADDR, 32'h1);
    wr(`CTRL_ADDR, 32'h1);
    wr(`IRQ_STS_ADDR, 32'h3);
    wr(`IRQ_MASK_ADDR, 32'h1);
    #1 chk("irq idle", o_irq, 1'b0);
    @(posedge i_core_clk);
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    n = 0;
    while (taken !== 3'h4 && n < 1500)
    begin
      @(posedge i_core_clk);
      n++;
    end
    #1;
    chk("stream wait", taken, 3'h4);
    chk("stream", result, PT);
    chk("irq", o_irq, 1'b1);
    wr(`IRQ_STS_ADDR, 32'h3);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk("irq clear", o_irq, 1'b0);
    $display("stream done");
    wr(`IRQ_MASK_ADDR, 32'h0);
    wr(`DMA_CFG_ADDR, 32'h0);
    wr(`CTRL_ADDR, 32'h0);
    for (int w = 0; w < 4; w++)
      wr(12'(`WIN_FIRST + w), 32'hA5A5A5A5);
    repeat (50) @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rc("ctrl again", `CTRL_ADDR, {24'h0, `CTRL_RESET});
    // Clock enable low must freeze the control register
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    wr(`CTRL_ADDR, 32'h81);
    i_ce <= 1'b1;
    rc("frozen", `CTRL_ADDR, {24'h0, `CTRL_RESET});
    load_key();
    run_row(rows[0]);
    $display("second reset done");
    test_done();
  end

  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      test_done();
    end
  end
endmodule // test_block_cipher_accelerator
